// ===== inc/adc_test_pattern_pkg.sv
// Purpose: Shared constants for the converter output and test-pattern block.
// Assumes: APB register map with 32-bit data, one register per aligned word.
// Notes: Pattern words and sequences are fixed by the output format.
package adc_test_pattern_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;

    localparam int CONFIG_W = 5;
    localparam int CFG_PATTERN_BIT = 0;
    localparam int CFG_DEMUX_BIT = 1;
    localparam int CFG_DDR_BIT = 2;
    localparam int CFG_EDGE0_BIT = 3;
    localparam int CFG_CLK2_BIT = 4;
    localparam logic [4:0] CONFIG_RESET = 5'h02;

    localparam int EVENT_W = 2;
    localparam int EV_CLIP_BIT = 0;
    localparam int EV_START_BIT = 1;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    localparam int STATE_RUN_BIT = 0;
    localparam int STATE_HELD_BIT = 1;
    localparam int STATE_PATTERN_BIT = 2;

    localparam int WORD_W = 8;
    localparam int PORTS = 4;
    // Port order: 0 delayed Q, 1 delayed I, 2 Q, 3 I
    localparam logic [3:0][7:0] PATTERN_BASE = {8'h04, 8'h03, 8'h02, 8'h01};
    localparam logic [7:0] NONDEMUX_Q_BASE = 8'h01;
    localparam logic [7:0] NONDEMUX_I_BASE = 8'h02;
    localparam logic [3:0] DEMUX_LEN = 4'h5;
    localparam logic [3:0] NONDEMUX_LEN = 4'hA;
    // A one marks a complement word at that position of the cycle
    localparam logic [9:0] DEMUX_SEQ = 10'h00A;
    localparam logic [9:0] NONDEMUX_SEQ = 10'h132;

    localparam int CODE_MID = 128;
    localparam int CODE_TOP = 255;
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hFF;

    localparam logic [2:0] RELEASE_DELAY_DDR0 = 3'h4;
    localparam logic [2:0] RELEASE_DELAY_OTHER = 3'h3;
endpackage : adc_test_pattern_pkg

// ===== inc/pattern_link_if.sv
// Purpose: Carries control and pattern words between the output block and its generator.
// Assumes: Both ends run on clock_in.
// Notes: Words are combinational from the generator's counters.
`timescale 1ns/1ps
interface pattern_link_if;
    logic step;
    logic restart;
    logic slip;
    logic demux;
    logic [3:0][7:0] words;
    logic flag_i;
    logic flag_q;
    modport gen (input step, input restart, input slip, input demux, output words, output flag_i, output flag_q);
    modport use_side (output step, output restart, output slip, output demux, input words, input flag_i,
        input flag_q);
endinterface : pattern_link_if

// ===== rtl/pattern_gen.sv
// Purpose: Test-pattern sequencer for the four output ports.
// Assumes: One step per output word; restart has priority over step.
// Notes: The Q pair may lag the I pair by one word after an unaligned start.
`timescale 1ns/1ps
module pattern_gen (
    input wire logic clock_in,
    input wire logic rstn_in,
    pattern_link_if.gen link
);
    logic [3:0] idx_i;
    logic [3:0] idx_q;
    logic hold_q;
    logic [3:0] len;
    logic [9:0] seq;
    logic [3:0] next_idx_i;
    logic [3:0] next_idx_q;

    assign len = link.demux ? adc_test_pattern_pkg::DEMUX_LEN : adc_test_pattern_pkg::NONDEMUX_LEN;
    assign seq = link.demux ? adc_test_pattern_pkg::DEMUX_SEQ : adc_test_pattern_pkg::NONDEMUX_SEQ;
    assign next_idx_i = (idx_i == len - 4'h1) ? 4'h0 : idx_i + 4'h1;
    assign next_idx_q = (idx_q == len - 4'h1) ? 4'h0 : idx_q + 4'h1;

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            idx_i <= 4'h0;
            idx_q <= 4'h0;
            hold_q <= 1'b0;
        end else if (link.restart) begin
            idx_i <= 4'h0;
            idx_q <= 4'h0;
            hold_q <= link.slip;
        end else if (link.step) begin
            idx_i <= next_idx_i;
            if (hold_q) begin
                hold_q <= 1'b0;
            end else begin
                idx_q <= next_idx_q;
            end
        end
    end

    assign link.flag_i = seq[idx_i];
    assign link.flag_q = seq[idx_q];

    // Odd ports belong to the I pair, even ports to the Q pair
    generate
        for (genvar p = 0; p < adc_test_pattern_pkg::PORTS; p++) begin : g_port
            logic [7:0] base;
            logic comp;
            always_comb begin
                comp = (p % 2 == 1) ? link.flag_i : link.flag_q;
                if (link.demux) begin
                    base = adc_test_pattern_pkg::PATTERN_BASE[p];
                end else if (p == 2) begin
                    base = adc_test_pattern_pkg::NONDEMUX_Q_BASE;
                end else if (p == 3) begin
                    base = adc_test_pattern_pkg::NONDEMUX_I_BASE;
                end else begin
                    base = 8'h00;
                end
            end
            assign link.words[p] = (comp && (link.demux || p >= 2)) ? ~base : base;
        end
    endgenerate
endmodule : pattern_gen

// ===== rtl/adc_output_test_pattern.sv
// Purpose: Output-side logic of a dual 8-bit converter: code mapping, clipping and test pattern.
// Assumes: Sample clock and output-clock reset arrive as pins; converter values on clock_in.
// Notes: Registers over APB; pready answers one cycle into the access phase.
// Notes on behaviour
// - pattern enable replaces converter data everywhere
// - each port shows its word or its complement
// - demux base words 01h..04h, flag follows
// - demux cycle of five, ports together
// - non-demux uses Q and I only
// - non-demux cycle of ten words
// - unaligned start may slip Q pair
// - pattern starts when clock reset releases
// - pattern at full rate outside demux; in demux it steps on every second sample rise
// - output codes are offset binary
// - overrange saturates, never wraps
// - out-of-range high while beyond full scale
// - differential flag, or second clock
// - release caught on sample falling edge
// - clock resumes after three or four cycles
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module adc_output_test_pattern #(
    parameter int SAMPLE_W = 10
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic sample_clock_in,
    input wire logic output_clock_reset_in,
    input wire logic signed [SAMPLE_W-1:0] conv_i_in,
    input wire logic signed [SAMPLE_W-1:0] conv_q_in,
    output logic [7:0] delayed_q_port_out,
    output logic [7:0] delayed_i_port_out,
    output logic [7:0] q_port_out,
    output logic [7:0] i_port_out,
    output logic out_of_range_p_out,
    output logic out_of_range_n_out,
    output logic forwarded_output_clock_out,
    output logic irq_out
);
    typedef enum {ST_HELD, ST_WAIT_FALL, ST_DELAY, ST_RUN} release_state_type;

    release_state_type state;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] level;
    logic [1:0] level_d;
    logic sample_rise;
    logic sample_fall;
    logic clock_reset_held;
    logic [4:0] config_reg;
    logic [1:0] status;
    logic [1:0] mask;
    logic [2:0] delay_cnt;
    logic [2:0] delay_target;
    logic demux_phase;
    logic step;
    logic release_done;
    logic pattern_on;
    logic pattern_en_d;
    logic live_start;
    logic [8:0] map_i;
    logic [8:0] map_q;
    logic [8:0] held_i;
    logic [8:0] held_q;
    logic word_clip;
    logic access;
    logic bus_write;
    logic mapped;
    logic [31:0] next_rdata;

    pattern_link_if link ();

    pattern_gen u_pattern_gen (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .link(link)
    );

    // Bit 8 flags a clipped value, bits 7:0 hold the code
    function automatic logic [8:0] map_code(input logic signed [SAMPLE_W-1:0] v);
        logic signed [SAMPLE_W:0] sum;
        sum = SAMPLE_W'(v) + (SAMPLE_W + 1)'(adc_test_pattern_pkg::CODE_MID);
        if (sum < 0) begin
            map_code = {1'b1, adc_test_pattern_pkg::CODE_MIN};
        end else if (sum > (SAMPLE_W + 1)'(adc_test_pattern_pkg::CODE_TOP)) begin
            map_code = {1'b1, adc_test_pattern_pkg::CODE_MAX};
        end else begin
            map_code = {1'b0, sum[7:0]};
        end
    endfunction : map_code

    // Three-stage synchronisers; a level counts once stages two and three agree
    generate
        for (genvar s = 0; s < 2; s++) begin : g_sync
            always_ff @(posedge clock_in) begin
                if (!rstn_in) begin
                    sync1[s] <= 1'b0;
                    sync2[s] <= 1'b0;
                    sync3[s] <= 1'b0;
                    level[s] <= 1'b0;
                    level_d[s] <= 1'b0;
                end else begin
                    sync1[s] <= s == 0 ? sample_clock_in : output_clock_reset_in;
                    sync2[s] <= sync1[s];
                    sync3[s] <= sync2[s];
                    if (sync2[s] == sync3[s]) begin
                        level[s] <= sync3[s];
                    end
                    level_d[s] <= level[s];
                end
            end
        end
    endgenerate

    assign sample_rise = level[0] && !level_d[0];
    assign sample_fall = !level[0] && level_d[0];
    assign clock_reset_held = level[1];

    assign pattern_on = config_reg[adc_test_pattern_pkg::CFG_PATTERN_BIT];
    assign delay_target = (config_reg[adc_test_pattern_pkg::CFG_DEMUX_BIT] && config_reg[adc_test_pattern_pkg::CFG_DDR_BIT]
        && config_reg[adc_test_pattern_pkg::CFG_EDGE0_BIT]) ? adc_test_pattern_pkg::RELEASE_DELAY_DDR0
        : adc_test_pattern_pkg::RELEASE_DELAY_OTHER;
    assign release_done = (state == ST_DELAY) && sample_rise && (delay_cnt == delay_target - 3'h1);
    // Enabling outside clock reset starts at once, so the pairs may land one word apart
    assign live_start = pattern_on && !pattern_en_d && (state == ST_RUN);
    assign step = (state == ST_RUN) && sample_rise
        && (!config_reg[adc_test_pattern_pkg::CFG_DEMUX_BIT] || demux_phase);

    assign link.step = step;
    assign link.restart = release_done || live_start;
    assign link.slip = live_start;
    assign link.demux = config_reg[adc_test_pattern_pkg::CFG_DEMUX_BIT];

    // Release of the output-clock reset
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            state <= ST_RUN;
            delay_cnt <= 3'h0;
        end else if (clock_reset_held) begin
            state <= ST_HELD;
            delay_cnt <= 3'h0;
        end else begin
            case (state)
                ST_HELD: begin
                    state <= ST_WAIT_FALL;
                end
                ST_WAIT_FALL: begin
                    if (sample_fall) begin
                        state <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (release_done) begin
                        state <= ST_RUN;
                    end else if (sample_rise) begin
                        delay_cnt <= delay_cnt + 3'h1;
                    end
                end
                ST_RUN: begin
                    delay_cnt <= 3'h0;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Demux pairs two samples into one output word
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            demux_phase <= 1'b0;
            pattern_en_d <= 1'b0;
            held_i <= 9'h000;
            held_q <= 9'h000;
        end else begin
            pattern_en_d <= pattern_on;
            if (state != ST_RUN) begin
                demux_phase <= 1'b0;
            end else if (sample_rise) begin
                demux_phase <= !demux_phase;
                if (!demux_phase) begin
                    held_i <= map_code(conv_i_in);
                    held_q <= map_code(conv_q_in);
                end
            end
        end
    end

    assign map_i = map_code(conv_i_in);
    assign map_q = map_code(conv_q_in);
    assign word_clip = map_i[8] || map_q[8]
        || (config_reg[adc_test_pattern_pkg::CFG_DEMUX_BIT] && (held_i[8] || held_q[8]));

    // Output ports, out-of-range line and forwarded clock
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            delayed_q_port_out <= 8'h00;
            delayed_i_port_out <= 8'h00;
            q_port_out <= 8'h00;
            i_port_out <= 8'h00;
            out_of_range_p_out <= 1'b0;
            out_of_range_n_out <= 1'b1;
            forwarded_output_clock_out <= 1'b0;
        end else begin
            if (step) begin
                if (pattern_on) begin
                    delayed_q_port_out <= link.words[0];
                    delayed_i_port_out <= link.words[1];
                    q_port_out <= link.words[2];
                    i_port_out <= link.words[3];
                end else begin
                    q_port_out <= map_q[7:0];
                    i_port_out <= map_i[7:0];
                    delayed_q_port_out <= config_reg[adc_test_pattern_pkg::CFG_DEMUX_BIT] ? held_q[7:0] : 8'h00;
                    delayed_i_port_out <= config_reg[adc_test_pattern_pkg::CFG_DEMUX_BIT] ? held_i[7:0] : 8'h00;
                end
            end
            if (state != ST_RUN) begin
                forwarded_output_clock_out <= 1'b0;
            end else if (config_reg[adc_test_pattern_pkg::CFG_DDR_BIT]) begin
                if (step) begin
                    forwarded_output_clock_out <= !forwarded_output_clock_out;
                end
            end else if (step) begin
                forwarded_output_clock_out <= 1'b1;
            end else if (sample_fall) begin
                forwarded_output_clock_out <= 1'b0;
            end
            if (config_reg[adc_test_pattern_pkg::CFG_CLK2_BIT]) begin
                out_of_range_p_out <= forwarded_output_clock_out;
                out_of_range_n_out <= !forwarded_output_clock_out;
            end else if (step) begin
                out_of_range_p_out <= pattern_on ? link.flag_i : word_clip;
                out_of_range_n_out <= pattern_on ? !link.flag_i : !word_clip;
            end
        end
    end

    // APB slave: the answer comes one cycle into the access phase
    assign access = psel_in && penable_in && !pready_out;
    assign bus_write = psel_in && penable_in && pready_out && pwrite_in;
    assign mapped = paddr_in == adc_test_pattern_pkg::ADDR_CONFIG || paddr_in == adc_test_pattern_pkg::ADDR_STATUS
        || paddr_in == adc_test_pattern_pkg::ADDR_MASK || paddr_in == adc_test_pattern_pkg::ADDR_STATE;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr_in)
            adc_test_pattern_pkg::ADDR_CONFIG: next_rdata[4:0] = config_reg;
            adc_test_pattern_pkg::ADDR_STATUS: next_rdata[1:0] = status;
            adc_test_pattern_pkg::ADDR_MASK: next_rdata[1:0] = mask;
            adc_test_pattern_pkg::ADDR_STATE: begin
                next_rdata[adc_test_pattern_pkg::STATE_RUN_BIT] = state == ST_RUN;
                next_rdata[adc_test_pattern_pkg::STATE_HELD_BIT] = clock_reset_held;
                next_rdata[adc_test_pattern_pkg::STATE_PATTERN_BIT] = pattern_on;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= access;
            pslverr_out <= access && !mapped;
            prdata_out <= (access && !pwrite_in) ? next_rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            config_reg <= adc_test_pattern_pkg::CONFIG_RESET;
            mask <= adc_test_pattern_pkg::MASK_RESET;
        end else if (bus_write) begin
            if (paddr_in == adc_test_pattern_pkg::ADDR_CONFIG) begin
                config_reg <= pwdata_in[4:0];
            end
            if (paddr_in == adc_test_pattern_pkg::ADDR_MASK) begin
                mask <= pwdata_in[1:0];
            end
        end
    end

    // Sticky events: a set in the clearing cycle survives
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            status <= adc_test_pattern_pkg::STATUS_RESET;
            irq_out <= 1'b0;
        end else begin
            status[adc_test_pattern_pkg::EV_CLIP_BIT] <= (step && !pattern_on && word_clip)
                || (status[adc_test_pattern_pkg::EV_CLIP_BIT] && !(bus_write
                && paddr_in == adc_test_pattern_pkg::ADDR_STATUS && pwdata_in[adc_test_pattern_pkg::EV_CLIP_BIT]));
            status[adc_test_pattern_pkg::EV_START_BIT] <= (link.restart && pattern_on)
                || (status[adc_test_pattern_pkg::EV_START_BIT] && !(bus_write
                && paddr_in == adc_test_pattern_pkg::ADDR_STATUS && pwdata_in[adc_test_pattern_pkg::EV_START_BIT]));
            irq_out <= |(status & mask);
        end
    end
endmodule : adc_output_test_pattern

// ===== test/adc_output_test_pattern_assertions.sv
// Purpose: Port-level assertions for the converter output block.
// Assumes: One clock domain; only the top module's ports are visible.
// Notes: Pattern flag checks key on the demux words, so non-demux mode is not covered.
`timescale 1ns/1ps
module adc_output_test_pattern_assertions #(
    parameter int SAMPLE_W = 10
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sample_clock_in,
    input wire logic output_clock_reset_in,
    input wire logic signed [SAMPLE_W-1:0] conv_i_in,
    input wire logic signed [SAMPLE_W-1:0] conv_q_in,
    input wire logic [7:0] delayed_q_port_out,
    input wire logic [7:0] delayed_i_port_out,
    input wire logic [7:0] q_port_out,
    input wire logic [7:0] i_port_out,
    input wire logic out_of_range_p_out,
    input wire logic out_of_range_n_out,
    input wire logic forwarded_output_clock_out,
    input wire logic irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // Eight cycles outlast the pin synchroniser
    sequence clock_reset_held;
        output_clock_reset_in [*8];
    endsequence
    sequence apb_access;
        psel_in && penable_in && !pready_out;
    endsequence
    apb_answer_a: assert property (apb_access |=> pready_out)
        else $error("APB access not answered");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    prdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside answer");
    slverr_only_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    or_pair_a: assert property (out_of_range_n_out != out_of_range_p_out)
        else $error("out of range legs not complementary");
    clock_held_a: assert property (clock_reset_held |-> !forwarded_output_clock_out)
        else $error("forwarded clock runs under clock reset");
    ports_frozen_a: assert property (clock_reset_held |=> $stable(q_port_out) && $stable(i_port_out))
        else $error("ports move under clock reset");
    release_wait_a: assert property (clock_reset_held ##1 !output_clock_reset_in
        |-> (!forwarded_output_clock_out && $stable(q_port_out)) [*8])
        else $error("output resumed too early after release");
    pattern_high_a: assert property ((delayed_q_port_out == 8'hFE && delayed_i_port_out == 8'hFD
        && q_port_out == 8'hFC && i_port_out == 8'hFB) |-> out_of_range_p_out)
        else $error("flag low on complement words");
    pattern_low_a: assert property ((delayed_q_port_out == 8'h01 && delayed_i_port_out == 8'h02
        && q_port_out == 8'h03 && i_port_out == 8'h04) |-> !out_of_range_p_out)
        else $error("flag high on base words");
    reset_state_a: assert property (@(posedge clock_in) disable iff (1'b0) !rstn_in
        |=> (q_port_out == 8'h00 && !forwarded_output_clock_out && !irq_out && !pready_out))
        else $error("outputs not cleared by reset");
endmodule : adc_output_test_pattern_assertions

bind adc_output_test_pattern adc_output_test_pattern_assertions #(.SAMPLE_W(SAMPLE_W)) checker_i (
    .clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .sample_clock_in(sample_clock_in), .output_clock_reset_in(output_clock_reset_in),
    .conv_i_in(conv_i_in), .conv_q_in(conv_q_in), .delayed_q_port_out(delayed_q_port_out),
    .delayed_i_port_out(delayed_i_port_out), .q_port_out(q_port_out), .i_port_out(i_port_out),
    .out_of_range_p_out(out_of_range_p_out), .out_of_range_n_out(out_of_range_n_out),
    .forwarded_output_clock_out(forwarded_output_clock_out), .irq_out(irq_out));

// ===== test/capture_model.sv
// Purpose: Far-side capture logic, one word per forwarded clock edge.
// Assumes: Words settle within two system cycles of a forwarded clock edge.
// Notes: Both edges capture, so only DDR output gives one word per step.
`timescale 1ns/1ps
module capture_model (
    input wire logic clock_in,
    input wire logic fwd_clock_in,
    input wire logic [7:0] dq_in,
    input wire logic [7:0] di_in,
    input wire logic [7:0] q_in,
    input wire logic [7:0] i_in,
    input wire logic or_p_in
);
    logic [32:0] words[$];
    logic last_clock = 1'b0;
    logic [1:0] pending = 2'h0;
    // Late capture trades speed for margin against port update latency
    always @(posedge clock_in) begin
        last_clock <= fwd_clock_in;
        pending <= {pending[0], fwd_clock_in !== last_clock};
        if (pending[1]) begin
            words.push_back({or_p_in, dq_in, di_in, q_in, i_in});
        end
    end
endmodule : capture_model

// ===== test/adc_output_test_pattern_test.sv
// Purpose: Self-checking bench for the converter output and test-pattern block.
// Assumes: Sample clock free running at 200 ns, unrelated in phase to clock_in.
// Notes: After a clock reset release the pattern must open on its first word, all ports in step.
`timescale 1ns/1ps
module adc_output_test_pattern_test;
    logic clock_in = 1'b0, rstn_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sample_clock = 1'b0, clock_reset = 1'b0;
    logic signed [9:0] conv_i = 10'sh000, conv_q = 10'sh000;
    logic [7:0] dq, di, q, i;
    logic or_p, or_n, fwd_clock, irq;
    int errors = 0, n_compared = 0, cycles = 0;

    adc_output_test_pattern #(.SAMPLE_W(10)) adc_output_test_pattern_i (.clock_in(clock_in), .rstn_in(rstn_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sample_clock_in(sample_clock),
        .output_clock_reset_in(clock_reset), .conv_i_in(conv_i), .conv_q_in(conv_q), .delayed_q_port_out(dq),
        .delayed_i_port_out(di), .q_port_out(q), .i_port_out(i), .out_of_range_p_out(or_p),
        .out_of_range_n_out(or_n), .forwarded_output_clock_out(fwd_clock), .irq_out(irq));
    capture_model capture_model_i (.clock_in(clock_in), .fwd_clock_in(fwd_clock), .dq_in(dq), .di_in(di),
        .q_in(q), .i_in(i), .or_p_in(or_p));

    initial begin
        forever #12.5 clock_in = ~clock_in;
    end
    initial begin
        #37;
        forever #100 sample_clock = ~sample_clock;
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data, output logic [31:0] rd,
        output logic err);
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock_in);
        penable <= 1'b1;
        do @(posedge clock_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, data, rd, err);
        chk("write response", 33'h0, {32'h0, err});
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [32:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h0, rd, err);
        chk(name, exp, {err, rd});
    endtask : rd_chk

    task automatic wait_words(input int n);
        capture_model_i.words.delete();
        while (capture_model_i.words.size() < n) @(posedge clock_in);
    endtask : wait_words

    task automatic test_registers();
        rd_chk("config", adc_test_pattern_pkg::ADDR_CONFIG, 33'h002);
        rd_chk("status", adc_test_pattern_pkg::ADDR_STATUS, 33'h000);
        rd_chk("mask", adc_test_pattern_pkg::ADDR_MASK, 33'h000);
        rd_chk("state", adc_test_pattern_pkg::ADDR_STATE, 33'h001);
        rd_chk("unmapped", 8'h10, 33'h100000000);
    endtask : test_registers

    task automatic test_pattern(input string name, input logic [7:0] cfg, input int len, input logic [9:0] seq,
        input logic [31:0] base, input logic [31:0] flip);
        logic [32:0] exp;
        // Inputs beyond full scale must not reach the pattern
        conv_i <= 10'sh1F0;
        conv_q <= 10'sh210;
        clock_reset <= 1'b1;
        wr(adc_test_pattern_pkg::ADDR_CONFIG, {24'h0, cfg});
        wr(adc_test_pattern_pkg::ADDR_STATUS, 32'h3);
        rd_chk("held state", adc_test_pattern_pkg::ADDR_STATE, 33'h006);
        clock_reset <= 1'b0;
        wait_words(2 * len);
        for (int n = 0; n < 2 * len; n++) begin
            exp = seq[n % len] ? {1'b1, base ^ flip} : {1'b0, base};
            chk(name, exp, capture_model_i.words[n]);
        end
        rd_chk("start event", adc_test_pattern_pkg::ADDR_STATUS, 33'h002);
    endtask : test_pattern

    task automatic test_codes();
        logic signed [9:0] vals[6] = '{10'sh000, 10'sh3FF, 10'sh07F, 10'sh0C8, 10'sh2D4, 10'sh380};
        logic [7:0] codes[6] = '{8'h80, 8'h7F, 8'hFF, 8'hFF, 8'h00, 8'h00};
        logic flags[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        wr(adc_test_pattern_pkg::ADDR_CONFIG, 32'h6);
        for (int n = 0; n < 6; n++) begin
            conv_i <= vals[n];
            conv_q <= vals[n];
            wait_words(3);
            chk("code", {flags[n], {4{codes[n]}}}, capture_model_i.words[2]);
        end
        wr(adc_test_pattern_pkg::ADDR_CONFIG, 32'h16);
        wait_words(3);
        chk("or clock", {32'h0, !capture_model_i.words[1][32]}, {32'h0, capture_model_i.words[2][32]});
        wr(adc_test_pattern_pkg::ADDR_MASK, 32'h1);
        repeat (3) @(posedge clock_in);
        chk("irq raised", 33'h1, {32'h0, irq});
        wr(adc_test_pattern_pkg::ADDR_MASK, 32'h0);
        repeat (3) @(posedge clock_in);
        chk("irq masked", 33'h0, {32'h0, irq});
        wr(adc_test_pattern_pkg::ADDR_STATUS, 32'h3);
        wr(adc_test_pattern_pkg::ADDR_MASK, 32'h1);
        repeat (3) @(posedge clock_in);
        chk("irq cleared", 33'h0, {32'h0, irq});
        rd_chk("status cleared", adc_test_pattern_pkg::ADDR_STATUS, 33'h000);
    endtask : test_codes

    initial begin
        repeat (4) @(posedge clock_in);
        rstn_in <= 1'b1;
        test_registers();
        test_pattern("demux pattern", 8'h0F, 5, 10'h00A, 32'h01020304, 32'hFFFFFFFF);
        test_pattern("single pattern", 8'h05, 10, 10'h132, 32'h00000102, 32'h0000FFFF);
        test_codes();
        summarize();
    end
endmodule : adc_output_test_pattern_test
